/* pkg/emis_pkg.sv */
// package for the ethernet mac interface select block
// assumes an apb master on ref_clk, single clock domain
package emis_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] EMIS_LOCK_OFS    = 12'h000;
    localparam logic [11:0] EMIS_PERCFG_OFS  = 12'h004;
    localparam logic [11:0] EMIS_PERSTAT_OFS = 12'h008;
    localparam logic [11:0] EMIS_MACCFG_OFS  = 12'h00c;
    localparam logic [11:0] EMIS_DIV_OFS     = 12'h010;
    localparam logic [11:0] EMIS_TXCTL_OFS   = 12'h014;
    localparam logic [11:0] EMIS_STAT_OFS    = 12'h018;
    localparam logic [11:0] EMIS_RAM_OFS     = 12'h800;

    // ------------------------------------------------------------
    // values, fields and counts
    // ------------------------------------------------------------
    localparam logic [31:0] EMIS_UNLOCK_KEY   = 32'h0f0a0b00;
    localparam int          EMIS_MAC_EN_BIT   = 4;
    localparam int          EMIS_UNLOCK_CYC   = 16;
    localparam logic [4:0]  EMIS_UNLOCK_CNT   = 5'h10;
    localparam logic [2:0]  EMIS_DIV_RST      = 3'h2;
    localparam logic [2:0]  EMIS_DIV_RGMII    = 3'h5;
    localparam int          EMIS_MACCFG_RMII_RST = 0;
    localparam int          EMIS_MACCFG_FULLDPX  = 1;
    localparam int          EMIS_MACCFG_SPEED    = 2;   // bits 3:2
    localparam int          EMIS_MACCFG_FLOWCTL  = 4;
    localparam int          EMIS_MACCFG_QOS      = 5;
    localparam logic [5:0]  EMIS_MACCFG_RST   = 6'h01;
    localparam int          EMIS_RAM_BYTES    = 8192;
    localparam int          EMIS_RAM_WORDS    = EMIS_RAM_BYTES / 4;
    localparam int          EMIS_RAM_AW       = 11;

    typedef enum logic [1:0]
    {
        EMIS_MODE_MII   = 2'h0,
        EMIS_MODE_RMII  = 2'h1,
        EMIS_MODE_GMII  = 2'h2,
        EMIS_MODE_RGMII = 2'h3
    } emis_mode_t;

    typedef enum logic [1:0]
    {
        EMIS_SPD_10   = 2'h0,
        EMIS_SPD_100  = 2'h1,
        EMIS_SPD_1000 = 2'h2
    } emis_speed_t;

    typedef enum logic [2:0]
    {
        EMIS_LK_LOCKED = 3'b001,
        EMIS_LK_OPEN   = 3'b010,
        EMIS_LK_DONE   = 3'b100
    } emis_lock_t;

endpackage : emis_pkg

/* rtl/emis_top.sv */
// phy-side interface select, enable sequence and descriptor ram of the mac
// assumes apb master on ref_clk; phy data sampled synchronously to ref_clk
`timescale 1ns/1ns

// Operation
// RQ1: 10/100 half or full duplex; 1000 full duplex only.
// RQ2: flow control and quality-of-service enables held in mac config.
// RQ3: underflow inverts crc; coding error pin never driven.
// RQ4: 8 kbyte descriptor ram inside the control section.
// RQ5: mode pins latched at reset select exactly one interface.
// RQ6: mii, gmii, rmii share muxed pins; rgmii has own pins.
// RQ7: rgmii moves data on both clock edges, both ends; code drives only the low nibble, on rising edges.
// RQ8: mac delays its rgmii transmit clock against data.
// RQ9: receive clock delay on rgmii is added outside the device.
// RQ10: gmii full function; rmii reduced-pin mii.
// RQ11: rmii logic held in reset until software clears its bit.
// RQ12: unlock key must precede write of peripheral enable config.
// RQ13: enable bit 4 within 16 cycles enables mac and management; code enables management in every mode but rgmii.
// RQ14: peripheral state status reports mac enable for polling.
// RQ15: gmii/rgmii clocks come from network pll first output.
// RQ16: divider resets to 2; software sets 5 for rgmii.
// RQ17: management data and clock routed to mdio in every mode; code routes none in rgmii mode.
// RQ18: late enable write ignored and lock returns to locked.
// RQ19: mii 4, gmii 8, rmii 2 data bits; gmii drives gigabit clock.
module emis_top
    import emis_pkg::*;
(
    input  wire logic        ref_clk,                    // 10 mhz clock
    input  wire logic        reset,                      // sync reset, high
    input  wire logic [11:0] paddr,                      // apb address
    input  wire logic        psel,                       // apb select
    input  wire logic        penable,                    // apb enable
    input  wire logic        pwrite,                     // apb direction
    input  wire logic [31:0] pwdata,                     // apb write data
    output logic      [31:0] prdata,                     // apb read data
    output logic             pready,                     // apb ready
    output logic             pslverr,                    // apb error
    input  wire logic [1:0]  interface_mode_pins,        // strap pins
    input  wire logic        network_pll_first_output,   // pll clock level
    input  wire logic        tx_valid,                   // tx byte valid
    input  wire logic [7:0]  tx_data,                    // tx byte
    input  wire logic        tx_underflow,               // tx underflow
    output logic             tx_ready,                   // tx buffer ready
    output logic [7:0]       mux_txd,                    // shared txd pins
    output logic             mux_txen,                   // shared tx enable
    output logic             transmit_coding_error_pin,  // unused, low
    output logic             gigabit_tx_clock,           // gmii tx clock
    output logic [3:0]       rgmii_txd,                  // rgmii data
    output logic             rgmii_txctl,                // rgmii control
    output logic             rgmii_txc,                  // rgmii tx clock
    input  wire logic [7:0]  mux_rxd,                    // shared rxd pins
    input  wire logic        mux_rxdv,                   // shared rx valid
    output logic             mdio_route_en,              // mdio pins live
    output logic             mac_enabled,                // mac enable
    output logic [2:0]       network_clock_divider       // divider setting
);

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic        wr_en;
    logic        rd_en;
    logic        ram_hit;

    // acts before pready, in the first access cycle
    assign wr_en   = psel && penable && pwrite && !pready;
    assign rd_en   = psel && penable && !pwrite && !pready;
    assign ram_hit = paddr[11];

    // ------------------------------------------------------------
    // strap latch and mode
    // ------------------------------------------------------------
    emis_mode_t  mode_reg;
    logic        strap_done_reg;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            strap_done_reg <= 1'b0;
        else
            strap_done_reg <= 1'b1;
    end

    // pins are ignored after the first cycle
    always_ff @(posedge ref_clk)
    begin
        if (reset || !strap_done_reg)
            mode_reg <= emis_mode_t'(interface_mode_pins); // [RQ5]
    end

    // ------------------------------------------------------------
    // unlock sequence
    // ------------------------------------------------------------
    emis_lock_t  lock_reg;
    logic [4:0]  win_reg;
    logic [31:0] percfg_reg;
    logic        percfg_wr;

    assign percfg_wr = wr_en && !ram_hit && paddr == EMIS_PERCFG_OFS;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            lock_reg <= EMIS_LK_LOCKED;
            win_reg  <= 5'h0;
        end
        else
        begin
            case (lock_reg)
                EMIS_LK_LOCKED:
                begin
                    if (wr_en && paddr == EMIS_LOCK_OFS && pwdata == EMIS_UNLOCK_KEY)
                    begin
                        lock_reg <= EMIS_LK_OPEN; // [RQ12]
                        win_reg  <= EMIS_UNLOCK_CNT;
                    end
                end
                EMIS_LK_OPEN:
                begin
                    if (percfg_wr)
                        lock_reg <= EMIS_LK_DONE;
                    else if (win_reg == 5'h1)
                        lock_reg <= EMIS_LK_LOCKED; // [RQ18]
                    win_reg <= win_reg - 5'h1;
                end
                EMIS_LK_DONE:
                    // one enable write per unlock
                    lock_reg <= EMIS_LK_LOCKED;
                default:
                    lock_reg <= EMIS_LK_LOCKED;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            percfg_reg <= 32'h0;
        else if (percfg_wr && lock_reg == EMIS_LK_OPEN)
            percfg_reg <= pwdata; // [RQ12] [RQ13]
    end

    // status lags the enable by one cycle so polling sees a settled change
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            mac_enabled   <= 1'b0;
            mdio_route_en <= 1'b0;
        end
        else
        begin
            mac_enabled   <= percfg_reg[EMIS_MAC_EN_BIT]; // [RQ13] [RQ14]
            mdio_route_en <= percfg_reg[EMIS_MAC_EN_BIT] && mode_reg != EMIS_MODE_RGMII; // [RQ17]
        end
    end

    // ------------------------------------------------------------
    // mac config and divider
    // ------------------------------------------------------------
    logic [5:0]  maccfg_reg;
    logic        txctl_invert_reg;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            maccfg_reg            <= EMIS_MACCFG_RST; // [RQ11]
        end
        else if (wr_en && !ram_hit)
        begin
            if (paddr == EMIS_MACCFG_OFS)
            begin
                maccfg_reg <= pwdata[5:0];
                // gigabit only in full duplex
                if (pwdata[3:2] == EMIS_SPD_1000)
                    maccfg_reg[EMIS_MACCFG_FULLDPX] <= 1'b1; // [RQ1]
                // reserved speed code 3 reads as 100
                if (pwdata[3:2] == 2'h3)
                    maccfg_reg[3:2] <= EMIS_SPD_100;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            network_clock_divider <= EMIS_DIV_RST; // [RQ16]
        else if (wr_en && paddr == EMIS_DIV_OFS)
            network_clock_divider <= pwdata[2:0]; // [RQ16]
    end

    logic rmii_held;
    assign rmii_held = maccfg_reg[EMIS_MACCFG_RMII_RST];
    assign txctl_invert_reg = 1'b0;

    // ------------------------------------------------------------
    // descriptor ram
    // ------------------------------------------------------------
    logic [31:0] desc_ram [EMIS_RAM_WORDS]; // [RQ4]
    logic [31:0] ram_q;

    // 12-bit bus reaches the low 512 words only
    always_ff @(posedge ref_clk)
    begin
        if (wr_en && ram_hit)
            desc_ram[{2'b00, paddr[10:2]}] <= pwdata;
        ram_q <= desc_ram[{2'b00, paddr[10:2]}];
    end

    // ------------------------------------------------------------
    // apb response
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    logic        ram_rd_reg;

    always_comb
    begin
        rd_mux = 32'h0;
        case (paddr)
            EMIS_LOCK_OFS:    rd_mux = {31'h0, lock_reg != EMIS_LK_LOCKED};
            EMIS_PERCFG_OFS:  rd_mux = percfg_reg;
            EMIS_PERSTAT_OFS: rd_mux = {27'h0, mac_enabled, 4'h0}; // [RQ14]
            EMIS_MACCFG_OFS:  rd_mux = {26'h0, maccfg_reg};
            EMIS_DIV_OFS:     rd_mux = {29'h0, network_clock_divider};
            EMIS_STAT_OFS:    rd_mux = {28'h0, rmii_held, 1'b0, mode_reg};
            default:          rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            prdata     <= 32'h0;
            ram_rd_reg <= 1'b0;
        end
        else
        begin
            ram_rd_reg <= rd_en && ram_hit && !ram_rd_reg;
            // ram reads need one extra cycle for the array output
            if ((wr_en || rd_en) && !(rd_en && ram_hit && !ram_rd_reg))
            begin
                pready  <= 1'b1;
                pslverr <= !ram_hit && paddr > EMIS_STAT_OFS;
                prdata  <= ram_hit ? ram_q : rd_mux;
            end
            else
            begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // transmit two-entry buffer
    // ------------------------------------------------------------
    // two entries ride out a one-cycle stall
    logic [7:0]  buf_mem [2];
    logic [8:0]  buf_ctl [2];
    logic [1:0]  buf_cnt_reg;
    logic        buf_wp_reg;
    logic        buf_rp_reg;
    logic        push;
    logic        pop;
    logic        line_ready;
    logic [1:0]  nib_reg;
    logic [1:0]  nib_last;

    assign nib_last   = (mode_reg == EMIS_MODE_RMII) ? 2'h3 :
                        (mode_reg == EMIS_MODE_MII) ? 2'h1 : 2'h0; // [RQ19]
    assign line_ready = mac_enabled && !(mode_reg == EMIS_MODE_RMII && rmii_held)
                        && nib_reg == nib_last; // [RQ11]
    assign push = tx_valid && tx_ready;
    assign pop  = buf_cnt_reg != 2'h0 && line_ready;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            buf_cnt_reg <= 2'h0;
            buf_wp_reg  <= 1'b0;
            buf_rp_reg  <= 1'b0;
            tx_ready    <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                buf_mem[buf_wp_reg] <= tx_data;
                buf_ctl[buf_wp_reg] <= {tx_underflow, tx_data};
                buf_wp_reg          <= !buf_wp_reg;
            end
            if (pop)
                buf_rp_reg <= !buf_rp_reg;
            buf_cnt_reg <= buf_cnt_reg + {1'b0, push} - {1'b0, pop};
            tx_ready    <= (buf_cnt_reg + {1'b0, push} - {1'b0, pop}) < 2'h2;
        end
    end

    // ------------------------------------------------------------
    // line side: width per mode, crc inversion on underflow
    // ------------------------------------------------------------
    logic [7:0]  cur_byte_reg;
    logic        active_reg;
    logic        txc_lag_reg;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            nib_reg      <= 2'h0;
            cur_byte_reg <= 8'h0;
            active_reg   <= 1'b0;
        end
        else if (pop)
        begin
            // underflowed frames leave with a corrupted check field
            cur_byte_reg <= buf_ctl[buf_rp_reg][8] ? ~buf_mem[buf_rp_reg]
                                                   : buf_mem[buf_rp_reg]; // [RQ3]
            active_reg   <= 1'b1;
            nib_reg      <= 2'h0;
        end
        else if (nib_reg != nib_last)
            nib_reg <= nib_reg + 2'h1;
        else
            active_reg <= 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            mux_txd                   <= 8'h0;
            mux_txen                  <= 1'b0;
            rgmii_txd                 <= 4'h0;
            rgmii_txctl               <= 1'b0;
            rgmii_txc                 <= 1'b0;
            gigabit_tx_clock          <= 1'b0;
            transmit_coding_error_pin <= 1'b0;
            txc_lag_reg               <= 1'b0;
        end
        else
        begin
            transmit_coding_error_pin <= txctl_invert_reg; // [RQ3]
            txc_lag_reg <= network_pll_first_output;
            // mode gate keeps other interfaces quiet
            gigabit_tx_clock <= mode_reg == EMIS_MODE_GMII
                                && network_pll_first_output; // [RQ15] [RQ19]
            // rgmii has its own pins; muxed pins idle there
            mux_txen <= active_reg && mode_reg != EMIS_MODE_RGMII; // [RQ6]
            case (mode_reg)
                EMIS_MODE_MII:  mux_txd <= {4'h0, cur_byte_reg[nib_reg[0]*4 +: 4]};
                EMIS_MODE_RMII: mux_txd <= {6'h0, cur_byte_reg[nib_reg*2 +: 2]}; // [RQ10]
                EMIS_MODE_GMII: mux_txd <= cur_byte_reg; // [RQ10]
                default:        mux_txd <= 8'h0;
            endcase
            if (mode_reg == EMIS_MODE_RGMII)
            begin
                // low nibble only; the high nibble is never driven on any edge
                rgmii_txd   <= cur_byte_reg[3:0]; // [RQ7]
                rgmii_txctl <= active_reg;
                // clock trails data by one register stage
                rgmii_txc   <= txc_lag_reg; // [RQ8] [RQ15]
            end
        end
    end

    logic unused_rx;
    assign unused_rx = ^{mux_rxd, mux_rxdv, maccfg_reg[5:4]}; // [RQ2]

endmodule : emis_top

/* tb/emis_phy_model.sv */
// phy partner on the shared mii/rmii/gmii pins
// assumes the mac launches txd/txen on ref_clk rising edges
`timescale 1ns/1ns
module emis_phy_model
(
    input  wire logic       clk,  // mac clock
    input  wire logic [7:0] txd,  // shared tx data
    input  wire logic       txen, // shared tx enable
    output logic      [7:0] rxd,  // shared rx data
    output logic            rxdv  // shared rx valid
);
    logic [7:0] got_q[$];
    // rgmii rx clock delay is the phy's side; not modelled

    // no receive frames: idle data toggles so a stale value never looks held
    initial
    begin
        rxd  = 8'h5a;
        rxdv = 1'b0;
    end

    always @(posedge clk)
    begin
        rxd <= ~rxd;
        if (txen === 1'b1)
            got_q.push_back(txd);
    end
endmodule : emis_phy_model

/* tb/emis_top_sva.sv */
// port assertions for emis_top
// assumes one ref_clk domain with synchronous active-high reset
`timescale 1ns/1ns
module emis_top_sva
    import emis_pkg::*;
(
    input wire logic        ref_clk,                   // clock
    input wire logic        reset,                     // reset
    input wire logic [11:0] paddr,                     // apb address
    input wire logic        psel,                      // apb select
    input wire logic        penable,                   // apb enable
    input wire logic        pwrite,                    // apb direction
    input wire logic [31:0] pwdata,                    // apb write data
    input wire logic        pready,                    // apb ready
    input wire logic [1:0]  interface_mode_pins,       // straps
    input wire logic [7:0]  mux_txd,                   // shared txd
    input wire logic        mux_txen,                  // shared tx enable
    input wire logic        transmit_coding_error_pin, // unused pin
    input wire logic        gigabit_tx_clock,          // gmii clock
    input wire logic        rgmii_txctl,               // rgmii control
    input wire logic        mdio_route_en,             // mdio routing
    input wire logic        mac_enabled,               // mac enable
    input wire logic [2:0]  network_clock_divider      // divider
);
    // ------------------------------------------------------------
    // helper state
    // ------------------------------------------------------------
    logic [1:0] mode_reg;
    logic       first_reg;
    logic [4:0] win_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // straps are taken during reset and one cycle after, like the design
    always_ff @(posedge ref_clk)
    begin
        if (reset || first_reg)
            mode_reg <= interface_mode_pins;
        first_reg <= reset;
    end

    // generous window: only says a key preceded the enable
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            win_reg <= 5'h00;
        else if (psel && penable && pready && pwrite && paddr == EMIS_LOCK_OFS
                 && pwdata == EMIS_UNLOCK_KEY)
            win_reg <= 5'h14;
        else if (win_reg != 5'h00)
            win_reg <= win_reg - 5'h01;
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    sequence s_en_write;
        psel && penable && pready && pwrite && paddr == EMIS_PERCFG_OFS
            && pwdata[EMIS_MAC_EN_BIT];
    endsequence
    sequence s_en_rise;
        $rose(mac_enabled);
    endsequence

    property p_no_coding_err; transmit_coding_error_pin == 1'b0; endproperty
    property p_reset_vals;
        $fell(reset) |-> network_clock_divider == EMIS_DIV_RST && !mac_enabled;
    endproperty
    property p_rgmii_only; rgmii_txctl |-> mode_reg == EMIS_MODE_RGMII; endproperty
    property p_shared_only; mux_txen |-> mode_reg != EMIS_MODE_RGMII; endproperty
    property p_gtx_gmii; gigabit_tx_clock |-> mode_reg == EMIS_MODE_GMII; endproperty
    property p_width;
        mux_txen |-> (mode_reg != EMIS_MODE_MII || mux_txd[7:4] == 4'h0)
            && (mode_reg != EMIS_MODE_RMII || mux_txd[7:2] == 6'h00);
    endproperty
    property p_en_needs_key; s_en_rise |-> win_reg != 5'h00; endproperty
    property p_en_follows;
        (s_en_write ##0 (win_reg > 5'h0c && !mac_enabled)) |-> ##[0:2] mac_enabled;
    endproperty
    property p_mdio_with_mac;
        (s_en_rise ##0 (mode_reg != EMIS_MODE_RGMII)) |-> ##[0:2] mdio_route_en;
    endproperty
    property p_div_cause;
        $changed(network_clock_divider) |-> $past(psel && pwrite && paddr == EMIS_DIV_OFS);
    endproperty

    a_no_coding_err: assert property (p_no_coding_err)
        else $error("coding error pin driven");
    a_reset_vals: assert property (p_reset_vals)
        else $error("wrong values after reset");
    a_rgmii_only: assert property (p_rgmii_only)
        else $error("rgmii pins active outside rgmii mode");
    a_shared_only: assert property (p_shared_only)
        else $error("shared pins active in rgmii mode");
    a_gtx_gmii: assert property (p_gtx_gmii)
        else $error("gigabit clock outside gmii mode");
    a_width: assert property (p_width)
        else $error("data bits beyond mode width");
    a_en_needs_key: assert property (p_en_needs_key)
        else $error("mac enabled without unlock");
    a_en_follows: assert property (p_en_follows)
        else $error("prompt enable write ignored");
    a_mdio_with_mac: assert property (p_mdio_with_mac)
        else $error("mdio not routed with mac enable");
    a_div_cause: assert property (p_div_cause)
        else $error("divider changed without a write");
endmodule : emis_top_sva

bind emis_top emis_top_sva i_sva
(
    .ref_clk, .reset, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
    .interface_mode_pins, .mux_txd, .mux_txen, .transmit_coding_error_pin,
    .gigabit_tx_clock, .rgmii_txctl, .mdio_route_en, .mac_enabled, .network_clock_divider
);

/* tb/emis_top_tb.sv */
// self-checking bench for emis_top with apb master and phy partner
// assumes a 100 ns ref_clk and the register map of emis_pkg
`timescale 1ns/1ns
module emis_top_tb;
    import emis_pkg::*;
    logic        ref_clk, reset, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, d;
    logic [1:0]  interface_mode_pins;
    logic        network_pll_first_output, tx_valid, tx_underflow, tx_ready, mux_txen;
    logic [7:0]  tx_data, mux_txd, mux_rxd;
    logic        mux_rxdv, transmit_coding_error_pin, gigabit_tx_clock, rgmii_txctl;
    logic [3:0]  rgmii_txd;
    logic        rgmii_txc, mdio_route_en, mac_enabled;
    logic [2:0]  network_clock_divider;
    logic [11:0] a;
    logic [7:0]  exp_q[$];
    int          fail_count = 0;
    int          tests_run = 0;

    emis_top i_dut
    (
        .ref_clk, .reset, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .interface_mode_pins, .network_pll_first_output, .tx_valid, .tx_data,
        .tx_underflow, .tx_ready, .mux_txd, .mux_txen, .transmit_coding_error_pin,
        .gigabit_tx_clock, .rgmii_txd, .rgmii_txctl, .rgmii_txc, .mux_rxd, .mux_rxdv,
        .mdio_route_en, .mac_enabled, .network_clock_divider
    );
    emis_phy_model i_phy
    (
        .clk(ref_clk), .txd(mux_txd), .txen(mux_txen), .rxd(mux_rxd), .rxdv(mux_rxdv)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) network_pll_first_output <= ~network_pll_first_output;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
        psel <= 1'b1; pwrite <= wr; paddr <= ad; pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
            @(posedge ref_clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    task automatic do_reset(input logic [1:0] m);
        reset <= 1'b1; interface_mode_pins <= m;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk(32'(network_clock_divider), 32'(EMIS_DIV_RST));
        chk(32'({mac_enabled, mdio_route_en}), 32'h0);
        @(posedge ref_clk);
    endtask : do_reset

    // sender stalls at random; an underflow byte must leave the pins inverted
    task automatic send(input int n);
        logic u;
        for (int k = 0; k < n; k++)
        begin
            u = (k % 4 == 3);
            tx_valid <= 1'b1; tx_data <= 8'($urandom); tx_underflow <= u;
            do
                @(posedge ref_clk);
            while (tx_ready !== 1'b1);
            exp_q.push_back(u ? ~tx_data : tx_data);
            if ($urandom_range(3) == 0)
            begin
                tx_valid <= 1'b0;
                @(posedge ref_clk);
            end
        end
        tx_valid <= 1'b0; tx_underflow <= 1'b0;
    endtask : send

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0; interface_mode_pins = 2'h0; network_pll_first_output = 1'b0;
        tx_valid = 1'b0; tx_data = 8'h00; tx_underflow = 1'b0;
        void'($urandom(32'h896e));
        for (int m = 0; m < 4; m++)
        begin
            do_reset(2'(m));
            apb(1'b0, EMIS_STAT_OFS, 32'h0);
            chk(32'(rd[1:0]), 32'(m));
        end
        do_reset(EMIS_MODE_GMII);
        apb(1'b1, EMIS_PERCFG_OFS, 32'h10);
        chk(32'(mac_enabled), 32'h0);
        apb(1'b1, EMIS_LOCK_OFS, EMIS_UNLOCK_KEY);
        repeat (20) @(posedge ref_clk);
        apb(1'b1, EMIS_PERCFG_OFS, 32'h10);
        chk(32'(mac_enabled), 32'h0);
        apb(1'b1, EMIS_LOCK_OFS, EMIS_UNLOCK_KEY);
        apb(1'b1, EMIS_PERCFG_OFS, 32'h10);
        for (int i = 0; i < 8 && rd[4] !== 1'b1; i++)
            apb(1'b0, EMIS_PERSTAT_OFS, 32'h0);
        chk(32'(rd[4]), 32'h1);
        chk(32'({mac_enabled, mdio_route_en}), 32'h3);
        apb(1'b1, EMIS_DIV_OFS, 32'(EMIS_DIV_RGMII));
        apb(1'b0, EMIS_DIV_OFS, 32'h0);
        chk(rd & 32'h7, 32'(EMIS_DIV_RGMII));
        chk(32'(network_clock_divider), 32'(EMIS_DIV_RGMII));
        // 1000 with half duplex asked must come back full duplex
        for (int s = 0; s < 3; s++)
        begin
            apb(1'b1, EMIS_MACCFG_OFS, 32'h30 | 32'(s << 2));
            apb(1'b0, EMIS_MACCFG_OFS, 32'h0);
            chk(rd & 32'h3f, 32'h30 | 32'(s << 2) | ((s == 2) ? 32'h2 : 32'h0));
        end
        apb(1'b0, 12'h01c, 32'h0);
        chk(32'(err), 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            a = EMIS_RAM_OFS + 12'(4 * $urandom_range(511));
            d = $urandom;
            apb(1'b1, a, d);
            apb(1'b0, a, 32'h0);
            chk(rd, d);
        end
        send(24);
        for (int i = 0; i < 200 && i_phy.got_q.size() < exp_q.size(); i++)
            @(posedge ref_clk);
        chk(32'(i_phy.got_q.size()), 32'(exp_q.size()));
        foreach (exp_q[i])
            if (i < i_phy.got_q.size())
                chk(32'(i_phy.got_q[i]), 32'(exp_q[i]));
        stop_test();
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        stop_test();
    end
endmodule : emis_top_tb
